// >>> rtl/alarm_route_pkg.sv
/*
  Shared constants and types for the alarm routing and DAC range register bank.
  Assumes one 50 MHz clock and an 8-bit register port with one-cycle strobes.
*/
`default_nettype none
package alarm_route_pkg;

  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 8;
  localparam int NUM_ALARMS  = 9;  // inputs 16..20, ext, thermal, temp high, temp low
  localparam int CHECK_CNT_W = 3;
  localparam int NUM_EVENTS  = 2;

  // register offsets
  localparam logic [ADDR_W-1:0] OFF_ROUTE_LO  = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_ROUTE_HI  = 8'h1d;
  localparam logic [ADDR_W-1:0] OFF_RANGE_AB  = 8'h1e;
  localparam logic [ADDR_W-1:0] OFF_STATUS_LO = 8'h70;
  localparam logic [ADDR_W-1:0] OFF_STATUS_HI = 8'h71;
  localparam logic [ADDR_W-1:0] OFF_MON_CTRL  = 8'h73;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT  = 8'h74;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLR   = 8'h75;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN    = 8'h76;

  // reset values
  localparam logic [DATA_W-1:0] RST_ROUTE_LO = 8'h00;
  localparam logic [DATA_W-1:0] RST_ROUTE_HI = 8'h00;
  localparam logic [DATA_W-1:0] RST_RANGE_AB = 8'h00;
  localparam logic [DATA_W-1:0] RST_MON_CTRL = 8'h00;

  // field positions
  localparam int ROUTE_LO_W      = 5;  // input16..input20 routes, bits 4:0
  localparam int ROUTE_HI_W      = 4;  // temp low, temp high, thermal, ext, bits 3:0
  localparam int LATCH_OFF_BIT   = 4;
  localparam int RANGE_A_LSB     = 0;
  localparam int RANGE_B_LSB     = 4;
  localparam int PIN_EN_BIT      = 0;
  localparam int CHECK_CNT_LSB   = 1;
  localparam int EV_ALARM_SET    = 0;
  localparam int EV_ALARM_CLEAR  = 1;

  // explicit ranges follow the low two bits of the range field
  typedef enum logic [1:0] {
    RANGE_NEG10_0 = 2'h0,
    RANGE_NEG5_0  = 2'h1,
    RANGE_0_10    = 2'h2,
    RANGE_0_5     = 2'h3
  } dac_range_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  typedef struct packed {
    logic [CHECK_CNT_W-1:0] cnt;
    logic                   status;
    logic                   acked;
  } filter_state_t;

endpackage
`default_nettype wire

// >>> rtl/alarm_filter.sv
/*
  One alarm channel: consecutive-check qualifier plus latched or live status bit.
  Assumes check_en is a one-cycle pulse per completed check and need is at least 1.
*/
`timescale 1ns/100ps
`default_nettype none
module alarm_filter
  import alarm_route_pkg::*;
(
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  // monitor side
  input  wire logic                   check_en,
  input  wire logic                   out_of_range,
  input  wire logic [CHECK_CNT_W-1:0] need,
  // control side
  input  wire logic                   latch_off,
  input  wire logic                   read_ack,
  output logic                        status
);

  filter_state_t st;
  filter_state_t next_st;
  logic          live;

  // live alarm means the run of out-of-range checks reached the limit
  // compare as at-least so a count lowered mid-run cannot leave the run stranded above it
  assign live   = (st.cnt >= need);
  assign status = st.status;

  always_comb begin
    next_st = st;
    // counter saturates at the limit so a long excursion stays qualified
    if (check_en) begin
      if (!out_of_range)
        next_st.cnt = '0;
      else if (st.cnt < need)
        next_st.cnt = st.cnt + 1'b1;
    end
    if (latch_off) begin
      next_st.status = live;
      next_st.acked  = 1'b0;
    end else begin
      if (read_ack && st.status)
        next_st.acked = 1'b1;
      // clear needs both a read and a gone condition; set wins since live blocks it
      if (live)
        next_st.status = 1'b1;
      else if (st.status && st.acked)
        next_st.status = 1'b0;
      if (!next_st.status)
        next_st.acked = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end

endmodule // alarm_filter
`default_nettype wire

// >>> rtl/range_resolve.sv
/*
  Resolves one DAC group range from its 3-bit field and the auto detector.
  Purely combinational; the caller registers the result.
*/
`timescale 1ns/100ps
`default_nettype none
module range_resolve
  import alarm_route_pkg::*;
(
  // programmed field and detector guess
  input  wire logic [2:0] sel,
  input  wire dac_range_t auto_range,
  // resolved range
  output dac_range_t      eff_range,
  output logic            overridden
);

  // top bit set means software picks the range outright
  always_comb begin
    overridden = sel[2];
    eff_range  = sel[2] ? dac_range_t'(sel[1:0]) : auto_range;
  end

endmodule // range_resolve
`default_nettype wire

// >>> rtl/alarm_route_dac_range_regs.sv
/*
  Alarm output routing, alarm status latching and DAC group A/B range registers.
  Assumes a simple register port (one-cycle strobes, read data one cycle later),
  synchronous alarm inputs and a one-cycle check pulse from the monitor sequencer.
*/
`timescale 1ns/100ps
`default_nettype none
module alarm_route_dac_range_regs
  import alarm_route_pkg::*;
(
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  // register port
  input  wire reg_req_t              req,
  output logic [DATA_W-1:0]          rdata,
  // monitor side
  input  wire logic                  check_en,
  input  wire logic [NUM_ALARMS-1:0] out_of_range,
  // auto range detector
  input  wire dac_range_t            auto_range_a,
  input  wire dac_range_t            auto_range_b,
  // outputs
  output logic                       alarm_output_pin,
  output dac_range_t                 range_a,
  output dac_range_t                 range_b,
  output logic                       range_a_override,
  output logic                       range_b_override,
  output logic                       irq
);

  typedef struct packed {
    logic [DATA_W-1:0]     route_lo;
    logic [DATA_W-1:0]     route_hi;
    logic [DATA_W-1:0]     range_ab;
    logic [DATA_W-1:0]     mon_ctrl;
    logic [NUM_EVENTS-1:0] irq_stat;
    logic [NUM_EVENTS-1:0] irq_en;
    logic [DATA_W-1:0]     rdata;
    logic                  pin;
    dac_range_t            rng_a;
    dac_range_t            rng_b;
    logic                  ovr_a;
    logic                  ovr_b;
    logic                  irq;
    logic [NUM_ALARMS-1:0] prev_status;
  } top_state_t;

  top_state_t st;
  top_state_t next_st;

  // decode used by both the write and read paths
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // alarm channels
  logic [NUM_ALARMS-1:0]  status;
  logic [NUM_ALARMS-1:0]  read_ack;
  logic [NUM_ALARMS-1:0]  route;
  logic [CHECK_CNT_W-1:0] need;
  logic                   latch_off;
  logic                   pin_en;

  assign latch_off = st.route_hi[LATCH_OFF_BIT];
  assign pin_en    = st.mon_ctrl[PIN_EN_BIT];
  // a zero count would qualify with no check at all, so it is treated as one check
  assign need = (st.mon_ctrl[CHECK_CNT_LSB +: CHECK_CNT_W] == '0) ? CHECK_CNT_W'(1)
              : st.mon_ctrl[CHECK_CNT_LSB +: CHECK_CNT_W];
  assign route = {st.route_hi[ROUTE_HI_W-1:0], st.route_lo[ROUTE_LO_W-1:0]};

  // reading a status register acknowledges the bits it shows
  always_comb begin
    read_ack = '0;
    if (req.rd && hit(req.addr, OFF_STATUS_LO))
      read_ack[ROUTE_LO_W-1:0] = '1;
    if (req.rd && hit(req.addr, OFF_STATUS_HI))
      read_ack[NUM_ALARMS-1:ROUTE_LO_W] = '1;
  end

  genvar g;
  generate
    for (g = 0; g < NUM_ALARMS; g++) begin : g_alarm
      alarm_filter u_filter (
        .core_clk     (core_clk),
        .rst          (rst),
        .check_en     (check_en),
        .out_of_range (out_of_range[g]),
        .need         (need),
        .latch_off    (latch_off),
        .read_ack     (read_ack[g]),
        .status       (status[g])
      );
    end
  endgenerate

  // range fields
  dac_range_t eff_a;
  dac_range_t eff_b;
  logic       ovr_a;
  logic       ovr_b;

  range_resolve u_range_a (
    .sel        (st.range_ab[RANGE_A_LSB +: 3]),
    .auto_range (auto_range_a),
    .eff_range  (eff_a),
    .overridden (ovr_a)
  );

  range_resolve u_range_b (
    .sel        (st.range_ab[RANGE_B_LSB +: 3]),
    .auto_range (auto_range_b),
    .eff_range  (eff_b),
    .overridden (ovr_b)
  );

  // events for the interrupt: any status bit rising or falling
  logic [NUM_EVENTS-1:0] events;
  logic [NUM_EVENTS-1:0] clr_mask;

  always_comb begin
    events                 = '0;
    events[EV_ALARM_SET]   = |(status & ~st.prev_status);
    events[EV_ALARM_CLEAR] = |(~status & st.prev_status);
    clr_mask = '0;
    if (req.wr && hit(req.addr, OFF_IRQ_CLR))
      clr_mask = req.wdata[NUM_EVENTS-1:0];
  end

  // register writes, read mux and output staging
  always_comb begin
    next_st             = st;
    next_st.prev_status = status;
    // whole bytes stored except for the interrupt enable, reserved bits included, so they read back as written
    if (req.wr) begin
      if (hit(req.addr, OFF_ROUTE_LO))
        next_st.route_lo = req.wdata;
      if (hit(req.addr, OFF_ROUTE_HI))
        next_st.route_hi = req.wdata;
      if (hit(req.addr, OFF_RANGE_AB))
        next_st.range_ab = req.wdata;
      if (hit(req.addr, OFF_MON_CTRL))
        next_st.mon_ctrl = req.wdata;
      if (hit(req.addr, OFF_IRQ_EN))
        next_st.irq_en = req.wdata[NUM_EVENTS-1:0];
    end
    // set beats clear when both land in one cycle
    next_st.irq_stat = (st.irq_stat & ~clr_mask) | events;

    // read data stand only in the cycle after the strobe
    next_st.rdata = '0;
    if (req.rd) begin
      case (req.addr)
        OFF_ROUTE_LO:  next_st.rdata = st.route_lo;
        OFF_ROUTE_HI:  next_st.rdata = st.route_hi;
        OFF_RANGE_AB:  next_st.rdata = st.range_ab;
        OFF_STATUS_LO: next_st.rdata = DATA_W'(status[ROUTE_LO_W-1:0]);
        OFF_STATUS_HI: next_st.rdata = DATA_W'(status[NUM_ALARMS-1:ROUTE_LO_W]);
        OFF_MON_CTRL:  next_st.rdata = st.mon_ctrl;
        OFF_IRQ_STAT:  next_st.rdata = DATA_W'(st.irq_stat);
        OFF_IRQ_EN:    next_st.rdata = DATA_W'(st.irq_en);
        default:       next_st.rdata = '0;                  // unmapped and write-only read zero
      endcase
    end

    // pin is the or of routed alarms, gated by the pin function enable
    next_st.pin   = pin_en & |(status & route);
    next_st.rng_a = eff_a;
    next_st.rng_b = eff_b;
    next_st.ovr_a = ovr_a;
    next_st.ovr_b = ovr_b;
    next_st.irq   = |(next_st.irq_stat & st.irq_en);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st          <= '0;
      st.route_lo <= RST_ROUTE_LO;
      st.route_hi <= RST_ROUTE_HI;
      st.range_ab <= RST_RANGE_AB;
      st.mon_ctrl <= RST_MON_CTRL;
    end else begin
      st <= next_st;
    end
  end

  assign rdata            = st.rdata;
  assign alarm_output_pin = st.pin;
  assign range_a          = st.rng_a;
  assign range_b          = st.rng_b;
  assign range_a_override = st.ovr_a;
  assign range_b_override = st.ovr_b;
  assign irq              = st.irq;

endmodule // alarm_route_dac_range_regs
`default_nettype wire

// >>> verif/regs_props.sv
/* port checker for the alarm routing and dac range register bank.
   assumes it is bound onto the top module and sees one clock domain. */
`timescale 1ns/100ps
`default_nettype none
module regs_props
  import alarm_route_pkg::*;
(
  // clock and reset
  input wire logic              core_clk,
  input wire logic              rst,
  // inputs of the bank
  input wire reg_req_t          req,
  input wire logic              check_en,
  // outputs of the bank
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              alarm_output_pin,
  input wire dac_range_t        range_a,
  input wire dac_range_t        range_b,
  input wire logic              range_a_override,
  input wire logic              range_b_override,
  input wire logic              irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // register writes that start a multi-cycle effect
  sequence range_wr;
    req.wr && req.addr == OFF_RANGE_AB;
  endsequence
  sequence pin_off_wr;
    req.wr && req.addr == OFF_MON_CTRL && !req.wdata[PIN_EN_BIT];
  endsequence
  rdata_idle_a: assert property (!req.rd |=> rdata == 8'h00) else $error("read data outside a read");
  unmapped_read_a: assert property (req.rd && req.addr == 8'h00 |=> rdata == 8'h00) else $error("unmapped read");
  clr_read_a: assert property (req.rd && req.addr == OFF_IRQ_CLR |=> rdata == 8'h00) else $error("clear reg read");
  range_a_a: assert property (range_wr ##0 req.wdata[2] |-> ##2
    (range_a_override && range_a == $past(req.wdata[1:0], 2))) else $error("group a range");
  range_b_a: assert property (range_wr ##0 req.wdata[6] |-> ##2
    (range_b_override && range_b == $past(req.wdata[5:4], 2))) else $error("group b range");
  range_auto_a: assert property (range_wr ##0 !req.wdata[2] |-> ##2 !range_a_override) else $error("auto range");
  pin_cause_a: assert property ($rose(alarm_output_pin) |-> $past(check_en, 3) || $past(req.wr, 2) || $past(req.wr, 3))
    else $error("pin rose without cause");
  pin_off_a: assert property (pin_off_wr |-> ##2 !alarm_output_pin) else $error("pin active while off");
  irq_mask_a: assert property (req.wr && req.addr == OFF_IRQ_EN && req.wdata == 8'h00 |-> ##2 !irq)
    else $error("irq while masked");
endmodule // regs_props
bind alarm_route_dac_range_regs regs_props u_props (.core_clk(core_clk), .rst(rst), .req(req),
  .check_en(check_en), .rdata(rdata), .alarm_output_pin(alarm_output_pin), .range_a(range_a),
  .range_b(range_b), .range_a_override(range_a_override), .range_b_override(range_b_override), .irq(irq));
`default_nettype wire

// >>> verif/check_seq_model.sv
/* model of the monitor sequencer feeding alarm conditions to the bank.
   assumes the bench sets the wanted conditions just after a clock edge. */
`timescale 1ns/100ps
`default_nettype none
module check_seq_model
  import alarm_route_pkg::*;
(
  // clock and reset
  input wire logic                   core_clk,
  input wire logic                   rst,
  // wanted conditions
  input wire logic [NUM_ALARMS-1:0]  bad,
  // to the bank
  output logic                       check_en,
  output logic [NUM_ALARMS-1:0]      out_of_range
);
  logic [1:0] phase;
  // one check every 4 cycles, so a 4-cycle excursion meets one check only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      phase <= 2'h0;
      check_en <= 1'b0;
      out_of_range <= '0;
    end else begin
      phase <= phase + 2'h1;
      check_en <= (phase == 2'h3);
      out_of_range <= bad;
    end
  end
endmodule // check_seq_model
`default_nettype wire

// >>> verif/alarm_route_dac_range_regs_test.sv
/* self-checking bench for the alarm routing and dac range register bank.
   assumes the register port contract of the bank and a 50 MHz clock. */
`timescale 1ns/100ps
`default_nettype none
module alarm_route_dac_range_regs_test;
  import alarm_route_pkg::*;
  logic                  core_clk = 1'b0;
  logic                  rst = 1'b1;
  reg_req_t              req = '0;
  logic [NUM_ALARMS-1:0] bad = '0;
  dac_range_t            auto_a = RANGE_0_10;
  dac_range_t            auto_b = RANGE_NEG5_0;
  logic                  check_en;
  logic [NUM_ALARMS-1:0] out_of_range;
  logic [7:0]            rdata;
  logic                  pin, ovr_a, ovr_b, irq;
  dac_range_t            range_a, range_b;
  int                    n_errors = 0;
  int                    checked = 0;
  int                    cycles = 0;
  always #10 core_clk = ~core_clk;
  alarm_route_dac_range_regs DUT (.core_clk(core_clk), .rst(rst), .req(req), .rdata(rdata),
    .check_en(check_en), .out_of_range(out_of_range), .auto_range_a(auto_a), .auto_range_b(auto_b),
    .alarm_output_pin(pin), .range_a(range_a), .range_b(range_b), .range_a_override(ovr_a),
    .range_b_override(ovr_b), .irq(irq));
  check_seq_model partner (.core_clk(core_clk), .rst(rst), .bad(bad), .check_en(check_en),
    .out_of_range(out_of_range));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bus cycles: strobe raised after one edge, dropped at the next
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    req <= '0;
    #1 chk(rdata, exp);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // holds a condition for at least n cycles; it stays until the next set_bad call
  task automatic set_bad(input logic [8:0] v, input int n);
    @(posedge core_clk);
    bad <= v;
    repeat (n - 1) @(posedge core_clk);
    #1;
  endtask
  task automatic t_regs;
    logic [2:0] a;
    rd(OFF_ROUTE_LO, 8'h00);
    rd(OFF_ROUTE_HI, 8'h00);
    rd(OFF_RANGE_AB, 8'h00);
    rd(OFF_IRQ_CLR, 8'h00);
    wr(OFF_RANGE_AB, 8'h88);
    rd(OFF_RANGE_AB, 8'h88);
    wr(OFF_ROUTE_LO, 8'he0);
    rd(OFF_ROUTE_LO, 8'he0);
    wr(8'h00, 8'h55);
    rd(8'h00, 8'h00);
    for (int k = 0; k < 8; k++) begin
      a = 3'(k);
      wr(OFF_RANGE_AB, {1'b0, ~a, 1'b0, a});
      wait_n(2);
      chk({7'h0, ovr_a}, {7'h0, a[2]});
      chk({6'h0, range_a}, {6'h0, a[2] ? a[1:0] : auto_a});
      chk({6'h0, range_b}, {6'h0, a[2] ? auto_b : ~a[1:0]});
      chk({7'h0, ovr_b}, {7'h0, ~a[2]});
    end
    // detector moves while group a is forced and group b defers
    @(posedge core_clk);
    auto_a <= RANGE_NEG10_0;
    auto_b <= RANGE_0_5;
    wait_n(2);
    chk({6'h0, range_a}, {6'h0, RANGE_0_5});
    chk({6'h0, range_b}, {6'h0, RANGE_0_5});
    $display("register test done");
  endtask
  task automatic t_alarm;
    wr(OFF_MON_CTRL, 8'h05); // pin on, two checks needed
    wr(OFF_ROUTE_LO, 8'h01);
    set_bad(9'h001, 4);
    set_bad(9'h000, 8);
    rd(OFF_STATUS_LO, 8'h00);
    set_bad(9'h001, 12);
    wait_n(2);
    chk({7'h0, pin}, 8'h01);
    set_bad(9'h000, 12);
    rd(OFF_STATUS_LO, 8'h01);
    wait_n(8);
    rd(OFF_STATUS_LO, 8'h00);
    chk({7'h0, pin}, 8'h00);
    set_bad(9'h001, 12);
    wr(OFF_MON_CTRL, 8'h04);
    wait_n(2);
    chk({7'h0, pin}, 8'h00);
    wr(OFF_MON_CTRL, 8'h05);
    wr(OFF_ROUTE_LO, 8'h00);
    wait_n(2);
    chk({7'h0, pin}, 8'h00);
    wr(OFF_ROUTE_HI, 8'h08);
    set_bad(9'h100, 12);
    wait_n(2);
    chk({7'h0, pin}, 8'h01);
    $display("latched alarm test done");
  endtask
  task automatic t_live;
    wr(OFF_ROUTE_HI, 8'h18);
    set_bad(9'h000, 12);
    set_bad(9'h100, 12);
    rd(OFF_STATUS_HI, 8'h08);
    set_bad(9'h000, 12);
    chk({7'h0, pin}, 8'h00);
    set_bad(9'h100, 12);
    wait_n(2);
    chk({7'h0, pin}, 8'h01);
    set_bad(9'h000, 12);
    chk({7'h0, pin}, 8'h00);
    rd(OFF_STATUS_HI, 8'h00);
    $display("live alarm test done");
  endtask
  task automatic t_irq;
    rd(OFF_IRQ_STAT, 8'h03);
    wr(OFF_IRQ_CLR, 8'h03);
    rd(OFF_IRQ_STAT, 8'h00);
    wr(OFF_IRQ_EN, 8'h01);
    wait_n(2);
    chk({7'h0, irq}, 8'h00);
    set_bad(9'h100, 12);
    wait_n(2);
    chk({7'h0, irq}, 8'h01);
    wr(OFF_IRQ_EN, 8'h00);
    wait_n(2);
    chk({7'h0, irq}, 8'h00);
    wr(OFF_IRQ_CLR, 8'h03);
    rd(OFF_IRQ_STAT, 8'h00);
    $display("interrupt test done");
  endtask
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      complete_run;
    end
  end
  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    t_regs;
    t_alarm;
    t_live;
    t_irq;
    complete_run;
  end
endmodule // alarm_route_dac_range_regs_test
`default_nettype wire
